// ==== include/bsf_cfg.svh ====
`ifndef BSF_CFG_SVH
`define BSF_CFG_SVH

// Register byte addresses on the APB.
`define BSF_ADDR_CMD 8'h00
`define BSF_ADDR_OPERAND 8'h04
`define BSF_ADDR_STATUS 8'h08
`define BSF_ADDR_PC 8'h0C
`define BSF_ADDR_IO_SEL 8'h10
`define BSF_ADDR_IO_DATA 8'h14
`define BSF_ADDR_ENGINE 8'h18

// Command word fields.
`define BSF_CMD_OP 4:0
`define BSF_CMD_BIT 10:8
`define BSF_CMD_IO 20:16
`define BSF_CMD_K 31:24
`define BSF_CMD_K_MSB 31

// Status register flag positions.
`define BSF_FLAG_I 7
`define BSF_FLAG_T 6
`define BSF_FLAG_H 5
`define BSF_FLAG_S 4
`define BSF_FLAG_V 3
`define BSF_FLAG_N 2
`define BSF_FLAG_Z 1
`define BSF_FLAG_C 0

// Reset values.
`define BSF_RST_CMD 32'h0000_0000
`define BSF_RST_OPERAND 8'h00
`define BSF_RST_STATUS_REGISTER 8'h00
`define BSF_RST_PC 16'h0000
`define BSF_RST_IO_SEL 5'h00
`define BSF_RST_PRDATA 32'h0000_0000

// Program counter step of one instruction word.
`define BSF_PC_STEP 16'h0001

`endif

// ==== include/bsf_pkg.sv ====
package bsf_pkg;

  typedef enum logic [4:0] {
    OP_BRANCH_IF_IRQ_ON,
    OP_BRANCH_IF_IRQ_OFF,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_LOGICAL_SHIFT_LEFT,
    OP_LOGICAL_SHIFT_RIGHT,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_SHIFT_RIGHT,
    OP_BIT_TO_TFLAG,
    OP_TFLAG_TO_BIT,
    OP_OVERFLOW_FLAG_ON,
    OP_OVERFLOW_FLAG_OFF,
    OP_HALF_CARRY_ON,
    OP_HALF_CARRY_OFF,
    OP_SIGN_FLAG_ON,
    OP_SIGN_FLAG_OFF,
    OP_ZERO_FLAG_ON,
    OP_ZERO_FLAG_OFF
  } bsf_op_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_BR2,
    ST_IO_WR
  } bsf_fsm_e;

  typedef struct packed {
    bsf_fsm_e state;
    logic [31:0] cmd;
    logic [7:0] operand;
    logic [7:0] status_register;
    logic [15:0] pc;
    logic [4:0] io_sel;
    logic [31:0] prdata;
  } bsf_state_s;

endpackage : bsf_pkg

// ==== verilog/bsf_io_mem.sv ====
`timescale 1ns/1ps
`default_nettype none

// I/O register space with one write port and a registered read port.
module bsf_io_mem (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_we,
  input wire logic [4:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [4:0] i_raddr,
  output logic [7:0] o_rdata
);

  logic [7:0] mem_q [0:31];

  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rdata <= 8'h00;
    end
    else
    begin
      o_rdata <= mem_q[i_raddr];
    end
  end

endmodule : bsf_io_mem

`default_nettype wire

// ==== verilog/bsf_datapath.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bsf_cfg.svh"

module bsf_datapath
  import bsf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_busy,
  output logic [7:0] o_status
);

  localparam bsf_state_s RST_STATE = '{
    state: ST_IDLE,
    cmd: `BSF_RST_CMD,
    operand: `BSF_RST_OPERAND,
    status_register: `BSF_RST_STATUS_REGISTER,
    pc: `BSF_RST_PC,
    io_sel: `BSF_RST_IO_SEL,
    prdata: `BSF_RST_PRDATA
  };

  bsf_state_s q;
  bsf_state_s d;
  bsf_op_e op;
  logic [2:0] bsel;
  logic [7:0] bmask;
  logic [15:0] koff;
  logic addr_hit;
  logic wr_acc;
  logic mem_we;
  logic [4:0] mem_waddr;
  logic [4:0] mem_raddr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;

  assign op = bsf_op_e'(q.cmd[`BSF_CMD_OP]);
  assign bsel = q.cmd[`BSF_CMD_BIT];
  assign bmask = 8'h01 << bsel;
  assign koff = {{8{q.cmd[`BSF_CMD_K_MSB]}}, q.cmd[`BSF_CMD_K]};

  // Address decode of the register map.
  always_comb
  begin
    case (i_paddr)
      `BSF_ADDR_CMD, `BSF_ADDR_OPERAND, `BSF_ADDR_STATUS, `BSF_ADDR_PC,
      `BSF_ADDR_IO_SEL, `BSF_ADDR_IO_DATA, `BSF_ADDR_ENGINE: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Writes wait while an instruction runs; reads never wait.
  assign o_pready = !(i_pwrite && (q.state != ST_IDLE));
  assign o_pslverr = i_psel && i_penable && !addr_hit;
  assign wr_acc = i_psel && i_penable && i_pwrite && o_pready && addr_hit;

  // The engine owns the I/O port while busy, software otherwise.
  assign mem_raddr = (q.state == ST_IDLE) ? q.io_sel : q.cmd[`BSF_CMD_IO];
  assign mem_we = (q.state == ST_IO_WR) || (wr_acc && (i_paddr == `BSF_ADDR_IO_DATA));
  assign mem_waddr = (q.state == ST_IO_WR) ? q.cmd[`BSF_CMD_IO] : q.io_sel;

  // Read-modify-write of one I/O bit.
  always_comb
  begin
    if (q.state != ST_IO_WR)
    begin
      mem_wdata = i_pwdata[7:0];
    end
    else if (op == OP_IO_BIT_SET)
    begin
      mem_wdata = mem_rdata | bmask;
    end
    else
    begin
      mem_wdata = mem_rdata & ~bmask;
    end
  end

  bsf_io_mem u_io_mem (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );

  always_comb
  begin
    logic [7:0] res;
    logic cout;
    logic is_shift;
    res = q.operand;
    cout = q.status_register[`BSF_FLAG_C];
    is_shift = 1'b1;
    d = q;
    // Read data is captured in the setup cycle.
    if (i_psel && !i_penable)
    begin
      case (i_paddr)
        `BSF_ADDR_CMD: d.prdata = q.cmd;
        `BSF_ADDR_OPERAND: d.prdata = {24'h000000, q.operand};
        `BSF_ADDR_STATUS: d.prdata = {24'h000000, q.status_register};
        `BSF_ADDR_PC: d.prdata = {16'h0000, q.pc};
        `BSF_ADDR_IO_SEL: d.prdata = {27'h0, q.io_sel};
        `BSF_ADDR_IO_DATA: d.prdata = {24'h000000, mem_rdata};
        `BSF_ADDR_ENGINE: d.prdata = {31'h0, q.state != ST_IDLE};
        default: d.prdata = 32'h0000_0000;
      endcase
    end
    if (wr_acc)
    begin
      case (i_paddr)
        `BSF_ADDR_CMD:
        begin
          d.cmd = i_pwdata;
          d.state = ST_EXEC;
        end
        `BSF_ADDR_OPERAND: d.operand = i_pwdata[7:0];
        `BSF_ADDR_STATUS: d.status_register = i_pwdata[7:0];
        `BSF_ADDR_PC: d.pc = i_pwdata[15:0];
        `BSF_ADDR_IO_SEL: d.io_sel = i_pwdata[4:0];
        default: d.state = q.state;
      endcase
    end
    // Shift and rotate results.
    case (op)
      OP_LOGICAL_SHIFT_LEFT:
      begin
        res = {q.operand[6:0], 1'b0};
        cout = q.operand[7];
      end
      OP_LOGICAL_SHIFT_RIGHT:
      begin
        res = {1'b0, q.operand[7:1]};
        cout = q.operand[0];
      end
      OP_ROTATE_LEFT_CARRY:
      begin
        res = {q.operand[6:0], q.status_register[`BSF_FLAG_C]};
        cout = q.operand[7];
      end
      OP_ROTATE_RIGHT_CARRY:
      begin
        res = {q.status_register[`BSF_FLAG_C], q.operand[7:1]};
        cout = q.operand[0];
      end
      OP_ARITH_SHIFT_RIGHT:
      begin
        res = {q.operand[7], q.operand[7:1]};
        cout = q.operand[0];
      end
      default: is_shift = 1'b0;
    endcase
    case (q.state)
      ST_IDLE: d.state = d.state;
      ST_EXEC:
      begin
        d.state = ST_IDLE;
        d.pc = q.pc + `BSF_PC_STEP;
        if (is_shift)
        begin
          d.operand = res;
          d.status_register[`BSF_FLAG_Z] = (res == 8'h00);
          d.status_register[`BSF_FLAG_C] = cout;
          d.status_register[`BSF_FLAG_N] = res[7];
          d.status_register[`BSF_FLAG_V] = res[7] ^ cout;
        end
        case (op)
          OP_BRANCH_IF_IRQ_ON:
          begin
            if (q.status_register[`BSF_FLAG_I])
            begin
              d.state = ST_BR2;
              d.pc = q.pc;
            end
          end
          OP_BRANCH_IF_IRQ_OFF:
          begin
            if (!q.status_register[`BSF_FLAG_I])
            begin
              d.state = ST_BR2;
              d.pc = q.pc;
            end
          end
          OP_IO_BIT_SET, OP_IO_BIT_CLEAR: d.state = ST_IO_WR;
          OP_BIT_TO_TFLAG: d.status_register[`BSF_FLAG_T] = q.operand[bsel];
          OP_TFLAG_TO_BIT: d.operand[bsel] = q.status_register[`BSF_FLAG_T];
          OP_OVERFLOW_FLAG_ON: d.status_register[`BSF_FLAG_V] = 1'b1;
          OP_OVERFLOW_FLAG_OFF: d.status_register[`BSF_FLAG_V] = 1'b0;
          OP_HALF_CARRY_ON: d.status_register[`BSF_FLAG_H] = 1'b1;
          OP_HALF_CARRY_OFF: d.status_register[`BSF_FLAG_H] = 1'b0;
          OP_SIGN_FLAG_ON: d.status_register[`BSF_FLAG_S] = 1'b1;
          OP_SIGN_FLAG_OFF: d.status_register[`BSF_FLAG_S] = 1'b0;
          OP_ZERO_FLAG_ON: d.status_register[`BSF_FLAG_Z] = 1'b1;
          OP_ZERO_FLAG_OFF: d.status_register[`BSF_FLAG_Z] = 1'b0;
          default: d.state = ST_IDLE;
        endcase
      end
      ST_BR2:
      begin
        d.pc = q.pc + koff + `BSF_PC_STEP;
        d.state = ST_IDLE;
      end
      ST_IO_WR: d.state = ST_IDLE;
      default: d.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      q <= RST_STATE;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_prdata = q.prdata;
  assign o_busy = (q.state != ST_IDLE);
  assign o_status = q.status_register;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  property p_br_on_taken;
    (q.state == ST_EXEC && op == OP_BRANCH_IF_IRQ_ON && q.status_register[`BSF_FLAG_I])
      |=> (q.state == ST_BR2) ##1 (q.state == ST_IDLE && q.pc == $past(q.pc, 2) + koff + `BSF_PC_STEP);
  endproperty
  a_br_on_taken: assert property (p_br_on_taken)
    else $error("Taken interrupt-on branch gave a wrong PC or timing.");

  property p_br_off_taken;
    (q.state == ST_EXEC && op == OP_BRANCH_IF_IRQ_OFF && !q.status_register[`BSF_FLAG_I])
      |=> (q.state == ST_BR2) ##1 (q.state == ST_IDLE && q.pc == $past(q.pc, 2) + koff + `BSF_PC_STEP);
  endproperty
  a_br_off_taken: assert property (p_br_off_taken)
    else $error("Taken interrupt-off branch gave a wrong PC or timing.");

  property p_br_not_taken;
    (q.state == ST_EXEC && ((op == OP_BRANCH_IF_IRQ_ON && !q.status_register[`BSF_FLAG_I])
      || (op == OP_BRANCH_IF_IRQ_OFF && q.status_register[`BSF_FLAG_I])))
      |=> (q.state == ST_IDLE && q.pc == $past(q.pc) + `BSF_PC_STEP);
  endproperty
  a_br_not_taken: assert property (p_br_not_taken)
    else $error("Branch not taken did not finish in one cycle.");

  property p_io_set;
    (q.state == ST_EXEC && op == OP_IO_BIT_SET)
      |=> (q.state == ST_IO_WR && mem_we && mem_wdata[bsel] && ((mem_wdata | bmask) == (mem_rdata | bmask)))
      ##1 (q.state == ST_IDLE && q.status_register == $past(q.status_register, 2));
  endproperty
  a_io_set: assert property (p_io_set)
    else $error("I/O bit set wrote wrong data or took wrong time.");

  property p_io_clr;
    (q.state == ST_EXEC && op == OP_IO_BIT_CLEAR)
      |=> (q.state == ST_IO_WR && mem_we && !mem_wdata[bsel] && ((mem_wdata | bmask) == (mem_rdata | bmask)))
      ##1 (q.state == ST_IDLE && q.status_register == $past(q.status_register, 2));
  endproperty
  a_io_clr: assert property (p_io_clr)
    else $error("I/O bit clear wrote wrong data or took wrong time.");

  property p_lsl;
    (q.state == ST_EXEC && op == OP_LOGICAL_SHIFT_LEFT)
      |=> (q.operand == {$past(q.operand[6:0]), 1'b0} && q.status_register[`BSF_FLAG_C] == $past(q.operand[7])
      && q.status_register[`BSF_FLAG_Z] == (q.operand == 8'h00) && q.status_register[`BSF_FLAG_V] == (q.operand[7] ^ $past(q.operand[7])));
  endproperty
  a_lsl: assert property (p_lsl)
    else $error("Logical shift left result or flags wrong.");

  property p_lsr;
    (q.state == ST_EXEC && op == OP_LOGICAL_SHIFT_RIGHT)
      |=> (q.operand == {1'b0, $past(q.operand[7:1])} && q.status_register[`BSF_FLAG_C] == $past(q.operand[0])
      && !q.status_register[`BSF_FLAG_N] && q.status_register[`BSF_FLAG_V] == $past(q.operand[0]));
  endproperty
  a_lsr: assert property (p_lsr)
    else $error("Logical shift right result or flags wrong.");

  property p_rol;
    (q.state == ST_EXEC && op == OP_ROTATE_LEFT_CARRY)
      |=> (q.operand == {$past(q.operand[6:0]), $past(q.status_register[`BSF_FLAG_C])}
      && q.status_register[`BSF_FLAG_C] == $past(q.operand[7]) && q.status_register[`BSF_FLAG_N] == q.operand[7]);
  endproperty
  a_rol: assert property (p_rol)
    else $error("Rotate left through carry result or flags wrong.");

  property p_ror;
    (q.state == ST_EXEC && op == OP_ROTATE_RIGHT_CARRY)
      |=> (q.operand == {$past(q.status_register[`BSF_FLAG_C]), $past(q.operand[7:1])}
      && q.status_register[`BSF_FLAG_C] == $past(q.operand[0]) && q.status_register[`BSF_FLAG_Z] == (q.operand == 8'h00));
  endproperty
  a_ror: assert property (p_ror)
    else $error("Rotate right through carry result or flags wrong.");

  property p_asr;
    (q.state == ST_EXEC && op == OP_ARITH_SHIFT_RIGHT)
      |=> (q.operand == {$past(q.operand[7]), $past(q.operand[7:1])} && q.status_register[`BSF_FLAG_C] == $past(q.operand[0]));
  endproperty
  a_asr: assert property (p_asr)
    else $error("Arithmetic shift right result or carry wrong.");

  property p_bst;
    (q.state == ST_EXEC && op == OP_BIT_TO_TFLAG)
      |=> (q.status_register[`BSF_FLAG_T] == $past(q.operand[bsel]) && {q.status_register[7], q.status_register[5:0]} == $past({q.status_register[7], q.status_register[5:0]})
      && $stable(q.operand));
  endproperty
  a_bst: assert property (p_bst)
    else $error("Bit to T copy wrong or disturbed other flags.");

  property p_bld;
    (q.state == ST_EXEC && op == OP_TFLAG_TO_BIT)
      |=> (q.operand[bsel] == $past(q.status_register[`BSF_FLAG_T]) && $stable(q.status_register)
      && (q.operand | bmask) == ($past(q.operand) | bmask));
  endproperty
  a_bld: assert property (p_bld)
    else $error("T to bit copy wrong or changed flags.");

  property p_ovf_force;
    (q.state == ST_EXEC && (op == OP_OVERFLOW_FLAG_ON || op == OP_OVERFLOW_FLAG_OFF))
      |=> (q.status_register[`BSF_FLAG_V] == ($past(op) == OP_OVERFLOW_FLAG_ON)
      && {q.status_register[7:4], q.status_register[2:0]} == $past({q.status_register[7:4], q.status_register[2:0]}));
  endproperty
  a_ovf_force: assert property (p_ovf_force)
    else $error("Overflow flag force wrong.");

  property p_half_force;
    (q.state == ST_EXEC && (op == OP_HALF_CARRY_ON || op == OP_HALF_CARRY_OFF))
      |=> (q.status_register[`BSF_FLAG_H] == ($past(op) == OP_HALF_CARRY_ON)
      && {q.status_register[7:6], q.status_register[4:0]} == $past({q.status_register[7:6], q.status_register[4:0]}));
  endproperty
  a_half_force: assert property (p_half_force)
    else $error("Half carry flag force wrong.");

  property p_sign_force;
    (q.state == ST_EXEC && (op == OP_SIGN_FLAG_ON || op == OP_SIGN_FLAG_OFF))
      |=> (q.status_register[`BSF_FLAG_S] == ($past(op) == OP_SIGN_FLAG_ON)
      && {q.status_register[7:5], q.status_register[3:0]} == $past({q.status_register[7:5], q.status_register[3:0]}));
  endproperty
  a_sign_force: assert property (p_sign_force)
    else $error("Signed test flag force wrong.");

  property p_zero_force;
    (q.state == ST_EXEC && (op == OP_ZERO_FLAG_ON || op == OP_ZERO_FLAG_OFF))
      |=> (q.status_register[`BSF_FLAG_Z] == ($past(op) == OP_ZERO_FLAG_ON)
      && {q.status_register[7:2], q.status_register[0]} == $past({q.status_register[7:2], q.status_register[0]}));
  endproperty
  a_zero_force: assert property (p_zero_force)
    else $error("Zero flag force wrong.");

endmodule : bsf_datapath

`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bsf_cfg.svh"

module testbench
  import bsf_pkg::*;
;
  logic i_clk;
  logic i_resetn;
  logic i_psel;
  logic i_penable;
  logic i_pwrite;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic o_busy;
  logic [7:0] o_status;
  int bad_count;
  int checked;

  bsf_datapath dut (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_busy(o_busy),
    .o_status(o_status)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic results();
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask : chk

  // One APB transfer; an idle cycle always separates two transfers.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // Pready only moves at a rising edge, so its settled value is what the next edge samples.
    #1;
    while (o_pready !== 1'b1 && n < 50)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk("pready_wait", 32'h0, (n >= 50) ? 32'h1 : 32'h0);
    @(posedge i_clk);
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic wrreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wrreg

  task automatic rdreg(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rdreg

  // Expected operand and status after one instruction.
  function automatic logic [15:0] alu(input int op, input logic [2:0] b, input logic [7:0] d, input logic [7:0] sr);
    logic [7:0] r;
    logic [7:0] s;
    logic c;
    r = d;
    s = sr;
    c = sr[0];
    case (op)
      OP_LOGICAL_SHIFT_LEFT: {c, r} = {d, 1'b0};
      OP_LOGICAL_SHIFT_RIGHT: {r, c} = {1'b0, d};
      OP_ROTATE_LEFT_CARRY: {c, r} = {d, sr[0]};
      OP_ROTATE_RIGHT_CARRY: {r, c} = {sr[0], d};
      OP_ARITH_SHIFT_RIGHT: {r, c} = {d[7], d};
      OP_BIT_TO_TFLAG: s[6] = d[b];
      OP_TFLAG_TO_BIT: r[b] = sr[6];
      OP_OVERFLOW_FLAG_ON, OP_OVERFLOW_FLAG_OFF: s[3] = (op == OP_OVERFLOW_FLAG_ON);
      OP_HALF_CARRY_ON, OP_HALF_CARRY_OFF: s[5] = (op == OP_HALF_CARRY_ON);
      OP_SIGN_FLAG_ON, OP_SIGN_FLAG_OFF: s[4] = (op == OP_SIGN_FLAG_ON);
      OP_ZERO_FLAG_ON, OP_ZERO_FLAG_OFF: s[1] = (op == OP_ZERO_FLAG_ON);
      default: s = sr;
    endcase
    if (op >= OP_LOGICAL_SHIFT_LEFT && op <= OP_ARITH_SHIFT_RIGHT)
    begin
      s[0] = c;
      s[1] = (r == 8'h00);
      s[2] = r[7];
      s[3] = r[7] ^ c;
    end
    return {r, s};
  endfunction : alu

  // Loads state, runs one instruction, then checks timing and every result.
  task automatic exec(input int op, input logic [7:0] d, input logic [7:0] sr, input logic [15:0] pc,
                      input logic [7:0] k);
    logic [2:0] b;
    logic [4:0] io;
    logic [7:0] iv;
    logic [15:0] m;
    logic [15:0] pce;
    logic [31:0] r;
    logic tk;
    int n;
    int cyc;
    b = 3'($urandom);
    io = 5'($urandom);
    iv = 8'($urandom);
    wrreg(`BSF_ADDR_IO_SEL, {27'h0, io});
    wrreg(`BSF_ADDR_IO_DATA, {24'h0, iv});
    wrreg(`BSF_ADDR_OPERAND, {24'h0, d});
    wrreg(`BSF_ADDR_STATUS, {24'h0, sr});
    wrreg(`BSF_ADDR_PC, {16'h0, pc});
    wrreg(`BSF_ADDR_CMD, {k, 3'h0, io, 5'h0, b, 3'h0, op[4:0]});
    #1;
    n = 0;
    while (o_busy === 1'b1 && n < 20)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    m = alu(op, b, d, sr);
    tk = (op == OP_BRANCH_IF_IRQ_ON && sr[7]) || (op == OP_BRANCH_IF_IRQ_OFF && !sr[7]);
    pce = tk ? pc + {{8{k[7]}}, k} + 16'h0001 : pc + 16'h0001;
    cyc = (tk || op == OP_IO_BIT_SET || op == OP_IO_BIT_CLEAR) ? 2 : 1;
    if (op == OP_IO_BIT_SET)
      iv[b] = 1'b1;
    if (op == OP_IO_BIT_CLEAR)
      iv[b] = 1'b0;
    chk("busy_cycles", cyc, n);
    chk("o_status", {24'h0, m[7:0]}, {24'h0, o_status});
    rdreg(`BSF_ADDR_OPERAND, r);
    chk("operand", {24'h0, m[15:8]}, r);
    rdreg(`BSF_ADDR_STATUS, r);
    chk("status", {24'h0, m[7:0]}, r);
    rdreg(`BSF_ADDR_PC, r);
    chk("pc", {16'h0, pce}, r);
    rdreg(`BSF_ADDR_IO_DATA, r);
    chk("io_data", {24'h0, iv}, r);
  endtask : exec

  initial
  begin
    repeat (40000) @(posedge i_clk);
    $display("Error watchdog expected finish seen timeout");
    bad_count++;
    results();
  end

  initial
  begin
    logic [31:0] r;
    logic e;
    i_resetn = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    bad_count = 0;
    checked = 0;
    void'($urandom(32'hFEEA));
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    rdreg(`BSF_ADDR_STATUS, r);
    chk("status_reset", 32'h0, r);
    rdreg(`BSF_ADDR_PC, r);
    chk("pc_reset", 32'h0, r);
    rdreg(`BSF_ADDR_ENGINE, r);
    chk("engine_idle", 32'h0, r);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("pslverr_read", 32'h1, {31'h0, e});
    apb(1'b1, 8'h3C, 32'hFFFF_FFFF, r, e);
    chk("pslverr_write", 32'h1, {31'h0, e});
    // Every opcode once, the unused code 19 included.
    for (int i = 0; i < 20; i++)
      exec(i, 8'($urandom), 8'($urandom), 16'($urandom), 8'($urandom)); // to
    exec(OP_LOGICAL_SHIFT_LEFT, 8'h80, 8'h00, 16'h0010, 8'h00);
    exec(OP_LOGICAL_SHIFT_RIGHT, 8'h01, 8'hFF, 16'h0010, 8'h00);
    exec(OP_ROTATE_LEFT_CARRY, 8'h00, 8'h01, 16'h0010, 8'h00);
    exec(OP_ROTATE_RIGHT_CARRY, 8'h01, 8'h00, 16'h0010, 8'h00);
    exec(OP_ARITH_SHIFT_RIGHT, 8'h81, 8'h00, 16'h0010, 8'h00);
    exec(OP_BRANCH_IF_IRQ_ON, 8'h5A, 8'h80, 16'h0000, 8'h80);
    exec(OP_BRANCH_IF_IRQ_ON, 8'h5A, 8'h7F, 16'hFFFF, 8'h80);
    exec(OP_BRANCH_IF_IRQ_OFF, 8'h5A, 8'h00, 16'hFFF0, 8'h7F);
    exec(OP_BRANCH_IF_IRQ_OFF, 8'h5A, 8'hFF, 16'hFFF0, 8'h7F);
    for (int i = 0; i < 200; i++)
      exec($urandom_range(0, 19), 8'($urandom), 8'($urandom), 16'($urandom), 8'($urandom)); // to
    results();
  end
endmodule : testbench

`default_nettype wire
